// File: logic/vih_pkg.sv
// Package of constants and types for the two-level vectored interrupt handler
//------------------------------------------------------------------------------
// Summary of operation
// - Seventeen flagged sources, each placed at low or high priority; reset is the eighteenth.
// - Pending flags set regardless of enable; disabled flags never request.
// - Enabled pending flag requests; long call issued at instruction end.
// - Routines end with return, resuming where the program left off.
// - Global enable bit seven of main enable gates every source.
// - Flags raised while globally disabled wait and are serviced later.
// - Vectoring clears only ext0, timer0, ext1, timer1 flags.
// - Flag still set after return requests again after one instruction.
// - Software setting a pending flag acts like a hardware event.
// - High priority preempts low routine; high routine is never preempted.
// - All sources reset to low; one priority bit per source.
// - Simultaneous requests: high priority serviced before low.
// - Equal priority ties go to the smaller fixed order number.
// - Vectors at 0x0003 plus eight per order; reset vector 0x0000.
// - Enable and priority bits map main, extended one, extended two.
// - Requests sampled and priority resolved every system clock.
// - Fastest response seven clocks: detect, finish, five-clock call.
// - After return one instruction runs; worst case nineteen clocks.
// - Equal or higher routine in service holds new request until return.
//------------------------------------------------------------------------------
package vih_pkg;

  // Sources with a pending flag (reset is the eighteenth source)
  localparam int NUM_SRC = 17;
  localparam int SRC_W   = 5;

  // Register addresses on the special-function register port
  localparam logic [7:0] ADDR_ENABLE_MAIN     = 8'ha8;
  localparam logic [7:0] ADDR_PRIORITY_MAIN   = 8'hb8;
  localparam logic [7:0] ADDR_ENABLE_EXT_ONE  = 8'he6;
  localparam logic [7:0] ADDR_ENABLE_EXT_TWO  = 8'he7;
  localparam logic [7:0] ADDR_PRIORITY_EXT_ONE = 8'hf6;
  localparam logic [7:0] ADDR_PRIORITY_EXT_TWO = 8'hf7;

  // Reset values
  localparam logic [7:0] RST_ENABLE_MAIN   = 8'h00;
  localparam logic [7:0] RST_PRIORITY_MAIN = 8'h80;
  localparam logic [7:0] RST_EXT_ONE       = 8'h00;
  localparam logic [1:0] RST_EXT_TWO       = 2'h0;

  // Field positions
  localparam int GLOBAL_EN_BIT = 7;
  localparam int MAIN_SRC_CNT  = 7;
  localparam int EXT1_SRC_CNT  = 8;
  localparam int EXT2_SRC_CNT  = 2;
  localparam int HW_CLR_CNT    = 4;

  // Vector layout
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [15:0] VECTOR_BASE  = 16'h0003;
  localparam int          VECTOR_SHIFT = 3;

  // Response timing in system clocks
  localparam int DETECT_CLKS       = 1;
  localparam int SINGLE_INSTR_CLKS = 1;
  localparam int LONG_CALL_CLKS        = 5;
  localparam int RETURN_FROM_ISR_CLKS         = 5;
  localparam int DIV_CLKS          = 8;
  localparam int MIN_RESPONSE_CLKS = DETECT_CLKS + SINGLE_INSTR_CLKS
                                     + LONG_CALL_CLKS;
  localparam int MAX_RESPONSE_CLKS = DETECT_CLKS + RETURN_FROM_ISR_CLKS + DIV_CLKS
                                     + LONG_CALL_CLKS;
  localparam logic [2:0] LONG_CALL_LAST = 3'(LONG_CALL_CLKS - 1);

  typedef enum logic [1:0] {ST_RUN, ST_CALL} vih_state_e;

  // Long call request handed to the core
  typedef struct packed {
    logic [15:0]      vector;
    logic [SRC_W-1:0] src;
    logic             high;
  } vih_call_s;

endpackage

// File: logic/vih_arbiter.sv
// Fixed-order arbiter: lowest set index wins
module vih_arbiter #(
  parameter int N = 17,
  parameter int W = 5
) (
  input  wire logic [N-1:0] req_in,
  output logic              valid_out,
  output logic [W-1:0]      idx_out
);

  always_comb begin
    valid_out = 1'b0;
    idx_out   = '0;
    // Scan downward so the smallest order number is left standing
    for (int i = N - 1; i >= 0; i--) begin
      if (req_in[i]) begin
        valid_out = 1'b1;
        idx_out   = W'(i);
      end
    end
  end

endmodule

// File: logic/vih_top.sv
// Two-level vectored interrupt handler: registers, arbitration, call control
module vih_top
  import vih_pkg::*;
(
  // Clock and reset
  input  wire logic                   SYS_CLK_IN,
  input  wire logic                   RST_N_IN,
  // Special-function register port
  input  wire logic [7:0]             SFR_ADDR_IN,
  input  wire logic                   SFR_WR_IN,
  input  wire logic                   SFR_RD_IN,
  input  wire logic [7:0]             SFR_WDATA_IN,
  output logic      [7:0]             SFR_RDATA_OUT,
  // Pending flag sources
  input  wire logic [NUM_SRC-1:0]     PEND_HW_SET_IN,
  input  wire logic [NUM_SRC-1:0]     PEND_SW_SET_IN,
  input  wire logic [NUM_SRC-1:0]     PEND_SW_CLR_IN,
  output logic      [NUM_SRC-1:0]     PEND_FLAGS_OUT,
  // Core sequencer
  input  wire logic                   INSTR_DONE_IN,
  input  wire logic                   RETURN_FROM_ISR_DONE_IN,
  output logic                        CALL_STB_OUT,
  output vih_pkg::vih_call_s          CALL_INFO_OUT,
  output logic                        CALL_BUSY_OUT,
  output logic      [1:0]             IN_SERVICE_OUT
);

  import vih_pkg::*;

  //----------------------------------------------------------------------------
  // Registers
  //----------------------------------------------------------------------------
  logic [7:0]         enable_main_reg;
  logic [6:0]         priority_main_reg;
  logic [7:0]         enable_ext_one_reg;
  logic [7:0]         priority_ext_one_reg;
  logic [1:0]         enable_ext_two_reg;
  logic [1:0]         priority_ext_two_reg;
  logic [NUM_SRC-1:0] pend_reg;
  logic [NUM_SRC-1:0] pend_next;
  logic               isv_hi_reg;
  logic               isv_lo_reg;
  logic               req_valid_reg;
  logic               req_high_reg;
  logic [SRC_W-1:0]   req_idx_reg;
  vih_state_e         state_reg;
  logic [2:0]         long_call_cnt_reg;
  vih_call_s          call_info_reg;
  logic               call_stb_reg;
  logic               call_busy_reg;
  logic [7:0]         rdata_reg;

  logic [NUM_SRC-1:0] en_vec;
  logic [NUM_SRC-1:0] prio_vec;
  logic               global_en;
  logic [NUM_SRC-1:0] hi_mask;
  logic [NUM_SRC-1:0] lo_mask;
  logic               hi_valid;
  logic               lo_valid;
  logic [SRC_W-1:0]   hi_idx;
  logic [SRC_W-1:0]   lo_idx;
  logic               decide;
  logic [NUM_SRC-1:0] hw_clr_mask;

  //----------------------------------------------------------------------------
  // Register writes
  //----------------------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      enable_main_reg      <= RST_ENABLE_MAIN;
      priority_main_reg    <= RST_PRIORITY_MAIN[6:0];
      enable_ext_one_reg   <= RST_EXT_ONE;
      priority_ext_one_reg <= RST_EXT_ONE;
      enable_ext_two_reg   <= RST_EXT_TWO;
      priority_ext_two_reg <= RST_EXT_TWO;
    end else if (SFR_WR_IN) begin
      case (SFR_ADDR_IN)
        ADDR_ENABLE_MAIN:      enable_main_reg      <= SFR_WDATA_IN;
        ADDR_PRIORITY_MAIN:    priority_main_reg    <= SFR_WDATA_IN[6:0];
        ADDR_ENABLE_EXT_ONE:   enable_ext_one_reg   <= SFR_WDATA_IN;
        ADDR_PRIORITY_EXT_ONE: priority_ext_one_reg <= SFR_WDATA_IN;
        ADDR_ENABLE_EXT_TWO:   enable_ext_two_reg   <= SFR_WDATA_IN[1:0];
        ADDR_PRIORITY_EXT_TWO: priority_ext_two_reg <= SFR_WDATA_IN[1:0];
        default: ;
      endcase
    end
  end

  // Read data is registered; unmapped addresses and reserved bits read zero,
  // except the unused top bit of the main priority register, which reads one
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rdata_reg <= 8'h00;
    end else if (SFR_RD_IN) begin
      case (SFR_ADDR_IN)
        ADDR_ENABLE_MAIN:      rdata_reg <= enable_main_reg;
        ADDR_PRIORITY_MAIN:    rdata_reg <= {1'b1, priority_main_reg};
        ADDR_ENABLE_EXT_ONE:   rdata_reg <= enable_ext_one_reg;
        ADDR_PRIORITY_EXT_ONE: rdata_reg <= priority_ext_one_reg;
        ADDR_ENABLE_EXT_TWO:   rdata_reg <= {6'h00, enable_ext_two_reg};
        ADDR_PRIORITY_EXT_TWO: rdata_reg <= {6'h00, priority_ext_two_reg};
        default:               rdata_reg <= 8'h00;
      endcase
    end
  end

  //----------------------------------------------------------------------------
  // Request resolution
  //----------------------------------------------------------------------------
  assign en_vec    = {enable_ext_two_reg, enable_ext_one_reg,
                      enable_main_reg[MAIN_SRC_CNT-1:0]};
  assign prio_vec  = {priority_ext_two_reg, priority_ext_one_reg,
                      priority_main_reg};
  assign global_en = enable_main_reg[GLOBAL_EN_BIT];

  // Disabled or globally blocked flags stay set but never request
  assign hi_mask = pend_reg & en_vec & prio_vec
                   & {NUM_SRC{global_en && !isv_hi_reg}};
  assign lo_mask = pend_reg & en_vec & ~prio_vec
                   & {NUM_SRC{global_en && !isv_hi_reg && !isv_lo_reg}};

  vih_arbiter #(.N(NUM_SRC), .W(SRC_W)) u_arb_hi (
    .req_in    (hi_mask),
    .valid_out (hi_valid),
    .idx_out   (hi_idx)
  );

  vih_arbiter #(.N(NUM_SRC), .W(SRC_W)) u_arb_lo (
    .req_in    (lo_mask),
    .valid_out (lo_valid),
    .idx_out   (lo_idx)
  );

  // One detection cycle: the winner is sampled on every clock
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      req_valid_reg <= 1'b0;
      req_high_reg  <= 1'b0;
      req_idx_reg   <= '0;
    end else begin
      req_valid_reg <= hi_valid || lo_valid;
      req_high_reg  <= hi_valid;
      req_idx_reg   <= hi_valid ? hi_idx : lo_idx;
    end
  end

  //----------------------------------------------------------------------------
  // Call sequencing
  //----------------------------------------------------------------------------
  // The boundary that ends a return never vectors, so the next instruction
  // always completes first even when a flag is still pending
  assign decide = INSTR_DONE_IN && !RETURN_FROM_ISR_DONE_IN && req_valid_reg
                  && (state_reg == ST_RUN);

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_reg     <= ST_RUN;
      long_call_cnt_reg <= 3'h0;
    end else begin
      case (state_reg)
        ST_RUN: begin
          if (decide) begin
            state_reg     <= ST_CALL;
            long_call_cnt_reg <= 3'h0;
          end
        end
        ST_CALL: begin
          // Core is busy with the five-clock call; no new decision meanwhile
          if (long_call_cnt_reg == LONG_CALL_LAST) begin
            state_reg <= ST_RUN;
          end else begin
            long_call_cnt_reg <= long_call_cnt_reg + 3'h1;
          end
        end
        default: state_reg <= ST_RUN;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      call_stb_reg  <= 1'b0;
      call_info_reg <= '{vector: RESET_VECTOR, src: '0, high: 1'b0};
    end else begin
      call_stb_reg <= decide;
      if (decide) begin
        call_info_reg.vector <= VECTOR_BASE
          + (16'(req_idx_reg) << VECTOR_SHIFT);
        call_info_reg.src    <= req_idx_reg;
        call_info_reg.high   <= req_high_reg;
      end
    end
  end

  // Busy flag kept in its own flop so the output carries no decode
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      call_busy_reg <= 1'b0;
    end else if (decide) begin
      call_busy_reg <= 1'b1;
    end else if ((state_reg == ST_CALL)
                 && (long_call_cnt_reg == LONG_CALL_LAST)) begin
      call_busy_reg <= 1'b0;
    end
  end

  // In-service levels; a return retires the highest active one
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      isv_hi_reg <= 1'b0;
      isv_lo_reg <= 1'b0;
    end else if (decide) begin
      if (req_high_reg) begin
        isv_hi_reg <= 1'b1;
      end else begin
        isv_lo_reg <= 1'b1;
      end
    end else if (RETURN_FROM_ISR_DONE_IN) begin
      if (isv_hi_reg) begin
        isv_hi_reg <= 1'b0;
      end else begin
        isv_lo_reg <= 1'b0;
      end
    end
  end

  //----------------------------------------------------------------------------
  // Pending flags
  //----------------------------------------------------------------------------
  always_comb begin
    hw_clr_mask = '0;
    if (decide && (req_idx_reg < SRC_W'(HW_CLR_CNT))) begin
      hw_clr_mask[req_idx_reg] = 1'b1;
    end
    // Any set beats any clear in the same cycle
    pend_next = (pend_reg & ~(hw_clr_mask | PEND_SW_CLR_IN))
                | PEND_HW_SET_IN | PEND_SW_SET_IN;
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pend_reg <= '0;
    end else begin
      pend_reg <= pend_next;
    end
  end

  //----------------------------------------------------------------------------
  // Outputs
  //----------------------------------------------------------------------------
  assign SFR_RDATA_OUT  = rdata_reg;
  assign PEND_FLAGS_OUT = pend_reg;
  assign CALL_STB_OUT   = call_stb_reg;
  assign CALL_INFO_OUT  = call_info_reg;
  assign CALL_BUSY_OUT  = call_busy_reg;
  assign IN_SERVICE_OUT = {isv_hi_reg, isv_lo_reg};

  //----------------------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  a_call_cause: assert property (
    CALL_STB_OUT |-> $past(INSTR_DONE_IN) && $past(req_valid_reg))
    else $error("call issued without a request at an instruction end");

  a_return_from_isr_gap: assert property (
    RETURN_FROM_ISR_DONE_IN |=> !CALL_STB_OUT)
    else $error("call issued on the return boundary itself");

  a_global_block: assert property (
    !global_en |-> ##2 !CALL_STB_OUT)
    else $error("call issued while globally disabled");

  a_vector_map: assert property (
    CALL_STB_OUT |-> CALL_INFO_OUT.vector
      == 16'h0003 + 16'(CALL_INFO_OUT.src) * 16'h0008)
    else $error("vector does not match source order");

  a_call_length: assert property (
    CALL_STB_OUT |-> CALL_BUSY_OUT [*5] ##1 !CALL_BUSY_OUT)
    else $error("long call window is not five clocks");

  a_high_first: assert property (
    CALL_STB_OUT && !CALL_INFO_OUT.high |-> $past(hi_mask, 2) == '0)
    else $error("low request served over a high one");

  a_no_hi_preempt: assert property (
    isv_hi_reg && $past(isv_hi_reg, 2) |-> !CALL_STB_OUT)
    else $error("high routine was preempted");

  a_hw_clear: assert property (
    CALL_STB_OUT && CALL_INFO_OUT.src < 5'd4
      && !$past(PEND_HW_SET_IN[0] | PEND_HW_SET_IN[1]
               | PEND_HW_SET_IN[2] | PEND_HW_SET_IN[3])
      && !$past(|PEND_SW_SET_IN)
      |-> !pend_reg[CALL_INFO_OUT.src])
    else $error("self-clearing flag left set after vectoring");

  a_set_sticky: assert property (
    |PEND_HW_SET_IN |=> (pend_reg & $past(PEND_HW_SET_IN))
      == $past(PEND_HW_SET_IN))
    else $error("hardware event lost");

  c_high_call: cover property (CALL_STB_OUT && CALL_INFO_OUT.high);
  c_low_call:  cover property (CALL_STB_OUT && !CALL_INFO_OUT.high);
  c_preempt:   cover property (CALL_STB_OUT && CALL_INFO_OUT.high
                               && isv_lo_reg);
  c_reentry:   cover property (RETURN_FROM_ISR_DONE_IN ##[2:20] CALL_STB_OUT);

endmodule

// File: testbench/vih_core_model.sv
// Core sequencer model: ends instructions and returns, stalls during calls
module vih_core_model
  import vih_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Bench control
  input  wire logic [3:0] instr_len_in,
  input  wire logic       return_from_isr_req_in,
  // Handler side
  input  wire logic       call_busy_in,
  output logic            instr_done_out,
  output logic            return_from_isr_done_out
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [3:0] cnt_reg;
  logic       return_from_isr_reg;
  logic [3:0] len;

  // A return runs for its own fixed length, whatever the bench asked
  assign len = return_from_isr_reg ? 4'(RETURN_FROM_ISR_CLKS) : instr_len_in;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_reg        <= 4'h0;
      return_from_isr_reg       <= 1'b0;
      instr_done_out <= 1'b0;
      return_from_isr_done_out  <= 1'b0;
    end else begin
      instr_done_out <= 1'b0;
      return_from_isr_done_out  <= 1'b0;
      if (return_from_isr_req_in) begin
        return_from_isr_reg <= 1'b1;
      end
      if (call_busy_in) begin
        cnt_reg <= 4'h0;
      end else if (cnt_reg + 4'h1 >= len) begin
        cnt_reg        <= 4'h0;
        instr_done_out <= 1'b1;
        return_from_isr_done_out  <= return_from_isr_reg;
        return_from_isr_reg       <= return_from_isr_req_in;
      end else begin
        cnt_reg <= cnt_reg + 4'h1;
      end
    end
  end
endmodule

// File: testbench/vih_top_test.sv
// Self-checking bench for the two-level vectored interrupt handler
module vih_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import vih_pkg::*;

  logic               clk, rst_n, wr, rd, stb, busy;
  logic [7:0]         addr, wdata, rdata, d;
  logic [NUM_SRC-1:0] hw_set, sw_set, sw_clr, flags;
  logic               instr_done, return_from_isr_done, return_from_isr_req;
  logic [3:0]         ilen;
  logic [1:0]         insvc;
  vih_call_s          info;
  int                 error_cnt, samples_checked, n, m;
  int                 since, since_cyc;
  int                 cycles = 0;

  typedef struct packed {
    logic [7:0]  en_m, en_1, pr_m, pr_1;
    logic [1:0]  en_2, pr_2;
    logic [16:0] set;
    logic [4:0]  src;
    logic        high;
  } vih_row_s;
  localparam vih_row_s ROWS [6] = '{
    '{8'hff, 8'hff, 8'h00, 8'h00, 2'h3, 2'h0, 17'h10010, 5'd4, 1'b0},
    '{8'hff, 8'hff, 8'h00, 8'h00, 2'h3, 2'h2, 17'h10001, 5'd16, 1'b1},
    '{8'hff, 8'hff, 8'h00, 8'h80, 2'h3, 2'h0, 17'h04200, 5'd14, 1'b1},
    '{8'hff, 8'hff, 8'h08, 8'h00, 2'h3, 2'h0, 17'h0000c, 5'd3, 1'b1},
    '{8'hff, 8'h00, 8'h00, 8'h00, 2'h3, 2'h0, 17'h08080, 5'd15, 1'b0},
    '{8'h81, 8'hff, 8'h00, 8'h00, 2'h3, 2'h0, 17'h00003, 5'd0, 1'b0}};
  localparam logic [7:0] RA [7] = '{ADDR_ENABLE_MAIN, ADDR_PRIORITY_MAIN,
    ADDR_ENABLE_EXT_ONE, ADDR_ENABLE_EXT_TWO, ADDR_PRIORITY_EXT_ONE,
    ADDR_PRIORITY_EXT_TWO, 8'h00};
  localparam logic [7:0] RS [7] = '{0, 8'h80, 0, 0, 0, 0, 0};
  localparam logic [7:0] WF [7] = '{8'hff, 8'hff, 8'hff, 8'h03, 8'hff,
    8'h03, 8'h00};

  vih_top u_dut (
    .SYS_CLK_IN     (clk),
    .RST_N_IN       (rst_n),
    .SFR_ADDR_IN    (addr),
    .SFR_WR_IN      (wr),
    .SFR_RD_IN      (rd),
    .SFR_WDATA_IN   (wdata),
    .SFR_RDATA_OUT  (rdata),
    .PEND_HW_SET_IN (hw_set),
    .PEND_SW_SET_IN (sw_set),
    .PEND_SW_CLR_IN (sw_clr),
    .PEND_FLAGS_OUT (flags),
    .INSTR_DONE_IN  (instr_done),
    .RETURN_FROM_ISR_DONE_IN   (return_from_isr_done),
    .CALL_STB_OUT   (stb),
    .CALL_INFO_OUT  (info),
    .CALL_BUSY_OUT  (busy),
    .IN_SERVICE_OUT (insvc)
  );

  vih_core_model u_core (
    .clk_in         (clk),
    .rst_n_in       (rst_n),
    .instr_len_in   (ilen),
    .return_from_isr_req_in    (return_from_isr_req),
    .call_busy_in   (busy),
    .instr_done_out (instr_done),
    .return_from_isr_done_out  (return_from_isr_done)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Instructions and clocks elapsed since the last return
  always @(posedge clk) begin
    since     <= return_from_isr_done ? 0 : since + int'(instr_done);
    since_cyc <= return_from_isr_done ? 0 : since_cyc + 1;
    cycles    <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      conclude();
    end
  end

  //----------------------------------------------------------------------
  // Bus cycles and comparisons
  //----------------------------------------------------------------------
  task automatic chk_stat(input logic [31:0] g, e, input string s);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: %s got %h exp %h", $time, s, g, e);
    end
  endtask
  task automatic chk_reg(input logic [7:0] g, e, input logic [7:0] a);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: reg %h got %h exp %h", $time, a, g, e);
    end
  endtask
  task automatic chk_call(input vih_call_s e);
    samples_checked++;
    if (stb !== 1'b1 || info !== e) begin
      error_cnt++;
      $display("Error at %0t: call %b %h exp %h", $time, stb, info, e);
    end
  endtask
  function automatic vih_call_s mk(input logic [4:0] s, input logic h);
    return '{vector: 16'h0003 + {8'h00, s, 3'h0}, src: s, high: h};
  endfunction
  task automatic sfr_wr(input logic [7:0] a, dat);
    @(posedge clk);
    addr  <= a;
    wdata <= dat;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic sfr_rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic set_regs(input vih_row_s r);
    sfr_wr(ADDR_ENABLE_MAIN, r.en_m);
    sfr_wr(ADDR_ENABLE_EXT_ONE, r.en_1);
    sfr_wr(ADDR_ENABLE_EXT_TWO, {6'h00, r.en_2});
    sfr_wr(ADDR_PRIORITY_MAIN, r.pr_m);
    sfr_wr(ADDR_PRIORITY_EXT_ONE, r.pr_1);
    sfr_wr(ADDR_PRIORITY_EXT_TWO, {6'h00, r.pr_2});
  endtask
  // Kind 0 sets by software, 1 clears, 2 is a hardware event
  task automatic pulse(input int k, input logic [16:0] msk);
    @(posedge clk);
    sw_set <= (k == 0) ? msk : '0;
    sw_clr <= (k == 1) ? msk : '0;
    hw_set <= (k == 2) ? msk : '0;
    @(posedge clk);
    {sw_set, sw_clr, hw_set} <= '0;
  endtask
  task automatic wait_call(input vih_call_s e);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (stb !== 1'b1 && n < 40);
    chk_call(e);
  endtask
  task automatic no_call(input int c);
    m = 0;
    repeat (c) begin
      @(negedge clk);
      m += int'(stb !== 1'b0);
    end
    chk_stat(m, 0, "unexpected call");
  endtask
  task automatic do_return_from_isr;
    @(posedge clk);
    return_from_isr_req <= 1'b1;
    @(posedge clk);
    return_from_isr_req <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (return_from_isr_done !== 1'b1 && n < 40);
    @(negedge clk);
  endtask
  task automatic serve(input logic [16:0] msk, input logic [4:0] s,
                       input logic h);
    pulse(0, msk);
    wait_call(mk(s, h));
    chk_stat(32'(flags[s]), 32'(s > 5'd3), "flag kept");
    chk_stat(32'(insvc), {30'h0, h, ~h}, "in service");
    pulse(1, 17'h1ffff);
    do_return_from_isr;
    chk_stat(32'(insvc), 0, "retired");
  endtask
  task automatic conclude;
    $display("Checked %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  //----------------------------------------------------------------------
  // Test sequence
  //----------------------------------------------------------------------
  initial begin
    {rst_n, wr, rd, return_from_isr_req, addr, wdata} = '0;
    {hw_set, sw_set, sw_clr} = '0;
    ilen = 4'h1;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk_stat({flags, insvc, stb, busy}, 0, "reset outputs");
    chk_stat(32'(info.vector), 0, "reset vector");
    for (int p = 0; p < 3; p++) begin
      for (int i = 0; i < 7; i++) begin
        if (p > 0) sfr_wr(RA[i], (p == 1) ? 8'hff : 8'h00);
        sfr_rd(RA[i]);
        chk_reg(d, (p == 1) ? WF[i] : RS[i], RA[i]);
      end
    end
    $display("Test registers done");
    for (int i = 0; i < 6; i++) begin
      set_regs(ROWS[i]);
      serve(ROWS[i].set, ROWS[i].src, ROWS[i].high);
    end
    set_regs(ROWS[0]);
    for (int i = 0; i < NUM_SRC; i++) begin
      serve(17'h1 << i, 5'(i), 1'b0);
    end
    $display("Test table done");
    // Fastest response from a hardware event
    sfr_wr(ADDR_ENABLE_MAIN, 8'h84);
    pulse(2, 17'h00004);
    wait_call(mk(5'd2, 1'b0));
    chk_stat(n, 3, "detect to call");
    m = 0;
    do begin
      @(negedge clk);
      m++;
    end while (busy === 1'b1 && m < 20);
    chk_stat(m, 5, "call length");
    do_return_from_isr;
    $display("Test latency done");
    // Global enable holds flags pending
    sfr_wr(ADDR_ENABLE_EXT_ONE, 8'h00);
    sfr_wr(ADDR_ENABLE_MAIN, 8'h10);
    pulse(0, 17'h00110);
    no_call(12);
    chk_stat(32'(flags), 32'h110, "pending held");
    sfr_wr(ADDR_ENABLE_MAIN, 8'h90);
    wait_call(mk(5'd4, 1'b0));
    pulse(1, 17'h00010);
    do_return_from_isr;
    no_call(12);
    pulse(1, 17'h1ffff);
    $display("Test global enable done");
    // Flag left set across a return, then a divide
    ilen <= 4'h8;
    sfr_wr(ADDR_ENABLE_MAIN, 8'ha0);
    pulse(0, 17'h00020);
    wait_call(mk(5'd5, 1'b0));
    do_return_from_isr;
    wait_call(mk(5'd5, 1'b0));
    chk_stat(since, 1, "one instruction");
    chk_stat(since_cyc, DIV_CLKS, "divide then call");
    pulse(1, 17'h00020);
    do_return_from_isr;
    ilen <= 4'h1;
    $display("Test re-entry done");
    // Preemption and nesting
    sfr_wr(ADDR_ENABLE_MAIN, 8'hff);
    sfr_wr(ADDR_PRIORITY_MAIN, 8'h60);
    pulse(0, 17'h00010);
    wait_call(mk(5'd4, 1'b0));
    pulse(1, 17'h00010);
    pulse(0, 17'h00001);
    no_call(12);
    pulse(0, 17'h00020);
    wait_call(mk(5'd5, 1'b1));
    chk_stat(32'(insvc), 32'h3, "nested");
    pulse(1, 17'h00020);
    pulse(0, 17'h00040);
    no_call(12);
    do_return_from_isr;
    chk_stat(32'(insvc), 32'h1, "high retired");
    wait_call(mk(5'd6, 1'b1));
    pulse(1, 17'h1ffff);
    do_return_from_isr;
    do_return_from_isr;
    chk_stat(32'(insvc), 0, "all retired");
    $display("Test preemption done");
    conclude();
  end
endmodule
